// ===== inc/acbd_pkg.sv
// acbd_pkg: command codes, field positions and counts for the decoder
// assumes: shared by the decoder top and its bit synchroniser
package acbd_pkg;
    localparam int          DATA_BITS      = 32;
    localparam logic [5:0]  DATA_LAST      = 6'h1f;
    localparam int          SYNC_STAGES    = 2;
    // field positions in the command byte
    localparam int          POS_DIR        = 3;
    localparam int          POS_MODE       = 7;
    localparam int          POS_REPEAT     = 6;
    localparam int          POS_IDX_HI     = 5;
    localparam int          POS_IDX_LO     = 4;
    localparam int          POS_PTR_HI     = 5;
    localparam int          POS_PTR_LO     = 3;
    // low three bit codes
    localparam logic [2:0]  LOW_CONFIG     = 3'h3;
    localparam logic [2:0]  LOW_SETUP      = 3'h5;
    localparam logic [2:0]  LOW_CONVERT    = 3'h0;
    localparam logic [2:0]  CAL_SELF_OFS   = 3'h1;
    localparam logic [2:0]  CAL_SELF_GAIN  = 3'h2;
    localparam logic [2:0]  CAL_SYS_OFS    = 3'h5;
    localparam logic [2:0]  CAL_SYS_GAIN   = 3'h6;
    localparam logic [7:0]  CMD_NULL       = 8'h00;
    // register selects
    localparam logic [2:0]  SEL_NONE       = 3'h0;
    localparam logic [2:0]  SEL_CONFIG     = 3'h1;
    localparam logic [2:0]  SEL_SETUP      = 3'h2;
    localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
    typedef enum logic [1:0] {
        ACBD_CMD   = 2'b00,
        ACBD_WRITE = 2'b01,
        ACBD_READ  = 2'b10
    } acbd_state_t;
endpackage : acbd_pkg

// ===== rtl/acbd_sync.sv
// acbd_sync: two flip-flop level synchroniser
// assumes: input is asynchronous to clock
`timescale 1ns/1ns
module acbd_sync
    import acbd_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)(
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    // first stage feeds only the second
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : acbd_sync

// ===== rtl/acbd_decoder.sv
// acbd_decoder: serial command byte decoder of the converter port
// assumes: host drives cs_n, sclk, sdi; sclk is the link clock, which
//          only runs while cs_n is low; mode 0 (sample rising edge)
// Function
// - byte 0000_d011 selects configuration register, bit3 is direction
// - direction bit zero means the next 32 bits are written
// - byte 00ii_d101 accesses setup register ii, direction one reads
// - byte 10pp_pccc starts calibration of type ccc, ccc 000 starts a conversion, others reserved
// - calibration pointer bits 5..3 pick one of eight setups
// - write takes 32 bits in, read shifts 32 bits out
// - after a 32-bit transfer the port waits for a command again
// - all-zero byte clears the port flag, continuous mode kept
`timescale 1ns/1ns
module acbd_decoder
    import acbd_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    output logic             sdo_o,
    output logic             sdo_oe_n,
    input  wire logic [31:0] config_rd,
    input  wire logic [31:0] setup_rd,
    output logic [2:0]       reg_sel,
    output logic [1:0]       setup_index,
    output logic             reg_wr,
    output logic [31:0]      reg_wdata,
    output logic             conv_start,
    output logic             repeat_conversion_flag,
    output logic [2:0]       conv_setup,
    output logic             cal_start,
    output logic [2:0]       setup_pointer_field,
    output logic [2:0]       calibration_type_field,
    output logic             port_flag
);
    // ---------------- link domain (sclk) ----------------
    acbd_state_t  st_r;
    logic [7:0]   sh_r;
    logic [2:0]   bcnt_r;
    logic [31:0]  wsh_r;
    logic [5:0]   dcnt_r;
    logic [7:0]   cmd_r;
    logic [31:0]  word_r;
    logic         cmd_tg_r = 1'b0; // toggles start level, no link reset
    logic         wr_tg_r  = 1'b0;
    logic [31:0]  rsh_r;
    logic         rd_load_r;
    logic [7:0]   byte_nxt;
    logic [2:0]   low_nxt;
    logic         cfg_hit;
    logic         set_hit;
    logic         rd_cfg_r;

    assign byte_nxt = {sh_r[6:0], sdi};
    assign low_nxt  = byte_nxt[2:0];
    assign cfg_hit  = byte_nxt[7:4] == 4'h0 && low_nxt == LOW_CONFIG;
    assign set_hit  = byte_nxt[7:6] == 2'h0 && low_nxt == LOW_SETUP;

    // command shifter and transfer sequencer; cs_n high aborts async to
    // sclk since the link clock may stop outside a frame
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            st_r   <= ACBD_CMD;
            sh_r   <= 8'h00;
            bcnt_r <= 3'h0;
            dcnt_r <= 6'h00;
        end
        else
        begin
            case (st_r)
                ACBD_CMD:
                begin
                    sh_r   <= byte_nxt;
                    bcnt_r <= bcnt_r + 3'h1;
                    if (bcnt_r == 3'h7)
                    begin
                        dcnt_r <= 6'h00;
                        if (cfg_hit || set_hit)
                            st_r <= byte_nxt[POS_DIR] ? ACBD_READ
                                                      : ACBD_WRITE;
                    end
                end
                ACBD_WRITE, ACBD_READ:
                begin
                    dcnt_r <= dcnt_r + 6'h01;
                    if (dcnt_r == DATA_LAST)
                        st_r <= ACBD_CMD;
                end
                default:
                    st_r <= ACBD_CMD;
            endcase
        end
    end

    // captured command and written word, published by toggles
    always_ff @(posedge sclk)
    begin
        if (st_r == ACBD_CMD && bcnt_r == 3'h7 && !cs_n)
        begin
            cmd_r    <= byte_nxt;
            cmd_tg_r <= ~cmd_tg_r;
            rd_cfg_r <= cfg_hit;
        end
        if (st_r == ACBD_WRITE)
        begin
            wsh_r <= {wsh_r[30:0], sdi};
            if (dcnt_r == DATA_LAST)
            begin
                word_r  <= {wsh_r[30:0], sdi};
                wr_tg_r <= ~wr_tg_r;
            end
        end
    end

    // read data shifted out on falling edge, msb first
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            rsh_r     <= WORD_RESET;
            rd_load_r <= 1'b0;
        end
        else if (st_r == ACBD_READ && !rd_load_r)
        begin
            rsh_r     <= rd_cfg_r ? config_rd : setup_rd;
            rd_load_r <= 1'b1;
        end
        else
        begin
            rsh_r <= {rsh_r[30:0], 1'b0};
            if (st_r != ACBD_READ)
                rd_load_r <= 1'b0;
        end
    end

    // sdo drives only in a read frame
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            sdo_o    <= 1'b0;
            sdo_oe_n <= 1'b1;
        end
        else
        begin
            sdo_o    <= (st_r == ACBD_READ && !rd_load_r) ?
                        (rd_cfg_r ? config_rd[31] : setup_rd[31]) :
                        rsh_r[30];
            sdo_oe_n <= !(st_r == ACBD_READ);
        end
    end

    // ---------------- system domain (clock) ----------------
    logic        cmd_tg_s;
    logic        wr_tg_s;
    logic        cmd_tg_d_r;
    logic        wr_tg_d_r;
    logic        cmd_ev;
    logic        wr_ev;
    logic [7:0]  cmd_s_r;
    logic [2:0]  cc;

    acbd_sync u_sync_cmd (
        .clock (clock),
        .srst  (srst),
        .d     (cmd_tg_r),
        .q     (cmd_tg_s)
    );
    acbd_sync u_sync_wr (
        .clock (clock),
        .srst  (srst),
        .d     (wr_tg_r),
        .q     (wr_tg_s)
    );

    assign cmd_ev = cmd_tg_s ^ cmd_tg_d_r;
    assign wr_ev  = wr_tg_s ^ wr_tg_d_r;
    assign cc     = cmd_r[2:0];

    // toggle edge detection
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cmd_tg_d_r <= 1'b0;
            wr_tg_d_r  <= 1'b0;
        end
        else
        begin
            cmd_tg_d_r <= cmd_tg_s;
            wr_tg_d_r  <= wr_tg_s;
        end
    end

    // register select held per command; cmd_r is stable once toggled
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            reg_sel     <= SEL_NONE;
            setup_index <= 2'h0;
            cmd_s_r     <= CMD_NULL;
        end
        else if (cmd_ev)
        begin
            cmd_s_r <= cmd_r;
            if (cmd_r[7:4] == 4'h0 && cc == LOW_CONFIG)
                reg_sel <= SEL_CONFIG;
            else if (cmd_r[7:6] == 2'h0 && cc == LOW_SETUP)
            begin
                reg_sel     <= SEL_SETUP;
                setup_index <= cmd_r[POS_IDX_HI:POS_IDX_LO];
            end
            else
                reg_sel <= SEL_NONE;
        end
    end

    // write strobe with its word
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            reg_wr    <= 1'b0;
            reg_wdata <= WORD_RESET;
        end
        else
        begin
            reg_wr <= wr_ev && !cmd_s_r[POS_DIR];
            if (wr_ev)
                reg_wdata <= word_r;
        end
    end

    // conversion, calibration and null command decode
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            conv_start             <= 1'b0;
            cal_start              <= 1'b0;
            repeat_conversion_flag <= 1'b0;
            conv_setup             <= 3'h0;
            setup_pointer_field    <= 3'h0;
            calibration_type_field <= 3'h0;
            port_flag              <= 1'b0;
        end
        else
        begin
            conv_start <= 1'b0;
            cal_start  <= 1'b0;
            if (cmd_ev && cmd_r[POS_MODE] && cc == LOW_CONVERT)
            begin
                conv_start             <= 1'b1;
                repeat_conversion_flag <= cmd_r[POS_REPEAT];
                conv_setup             <= cmd_r[POS_PTR_HI:POS_PTR_LO];
                port_flag              <= 1'b1;
            end
            else if (cmd_ev && cmd_r[7:6] == 2'b10 &&
                     (cc == CAL_SELF_OFS || cc == CAL_SELF_GAIN ||
                      cc == CAL_SYS_OFS || cc == CAL_SYS_GAIN))
            begin
                cal_start              <= 1'b1;
                calibration_type_field <= cc;
                setup_pointer_field    <= cmd_r[POS_PTR_HI:POS_PTR_LO];
            end
            else if (cmd_ev && cmd_r == CMD_NULL)
                port_flag <= 1'b0; // repeat flag untouched
        end
    end

    // checks
    null_keeps_a: assert property (@(posedge clock) disable iff (srst)
        cmd_ev && cmd_r == CMD_NULL |=> !port_flag &&
        $stable(repeat_conversion_flag))
        else $error("null command mishandled");
    conv_pulse_a: assert property (@(posedge clock) disable iff (srst)
        cmd_ev && cmd_r[7] && cc == 3'h0 |=> conv_start ##1 !conv_start)
        else $error("conversion start pulse wrong");
    cal_type_a: assert property (@(posedge clock) disable iff (srst)
        cal_start |-> calibration_type_field inside {3'h1, 3'h2, 3'h5, 3'h6})
        else $error("reserved calibration started");
    cal_ptr_a: assert property (@(posedge clock) disable iff (srst)
        cmd_ev && cmd_r[7:6] == 2'b10 && cc == 3'h1 |=>
        setup_pointer_field == $past(cmd_r[5:3]))
        else $error("setup pointer not taken");
    cfg_sel_a: assert property (@(posedge clock) disable iff (srst)
        cmd_ev && cmd_r[7:4] == 4'h0 && cc == 3'h3 |=> reg_sel == 3'h1)
        else $error("config not selected");
    setup_sel_a: assert property (@(posedge clock) disable iff (srst)
        cmd_ev && cmd_r[7:6] == 2'h0 && cc == 3'h5 |=>
        reg_sel == 3'h2 && setup_index == $past(cmd_r[5:4]))
        else $error("setup index wrong");
    wr_only_a: assert property (@(posedge clock) disable iff (srst)
        reg_wr |-> !cmd_s_r[3] && reg_sel != 3'h0)
        else $error("write on read command");
    word_len_a: assert property (@(posedge sclk) disable iff (cs_n)
        st_r == ACBD_WRITE && dcnt_r == 6'h1f |=> st_r == ACBD_CMD)
        else $error("transfer not 32 bits");
    back_cmd_a: assert property (@(posedge sclk) disable iff (cs_n)
        st_r == ACBD_READ && dcnt_r == 6'h1f |=> st_r == ACBD_CMD &&
        bcnt_r == 3'h0)
        else $error("no return to command mode");
endmodule : acbd_decoder

// ===== dv/acbd_host_model.sv
// acbd_host_model: host side of the four-wire serial port
// assumes: bench calls its tasks; sclk stands low outside frames
`timescale 1ns/1ns
module acbd_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo_o,
    input  wire logic sdo_oe_n
);
    logic sdo_line;
    logic last_q;
    // released line shows the inverse of its last driven level
    always @(sdo_o or sdo_oe_n) if (!sdo_oe_n) last_q = sdo_o;
    assign sdo_line = sdo_oe_n ? ~last_q : sdo_o;
    // idle levels at time zero
    initial
    begin
        sclk   = 1'b0;
        cs_n   = 1'b1;
        sdi    = 1'b0;
        last_q = 1'b0;
    end
    // chip select, then a gap that keeps byte spacing
    task automatic sel(input logic on);
        cs_n = ~on;
        #48;
    endtask : sel
    // shift n bits msb first at 12 ns, capture sdo on rising edge
    task automatic shift(input logic [31:0] tx, input int n,
                         output logic [31:0] rx);
        rx = 32'h0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi = tx[i];
            #6 sclk = 1'b1;
            rx = {rx[30:0], sdo_line};
            #6 sclk = 1'b0;
        end
        sdi = ~sdi;                      // data no longer held
        #48;
    endtask : shift
endmodule : acbd_host_model

// ===== dv/acbd_decoder_bench.sv
// acbd_decoder_bench: command byte scenarios against the decoder
// assumes: host model drives the port; register contents from bench
`timescale 1ns/1ns
`define CHECK(a, b) \
    begin \
        n_tests++; \
        if ((a) !== (b)) \
        begin \
            bad_count++; \
            $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); \
        end \
    end
module acbd_decoder_bench;
    import acbd_pkg::*;
    localparam logic [2:0] CALS [4] = '{CAL_SELF_OFS, CAL_SELF_GAIN,
                                        CAL_SYS_OFS, CAL_SYS_GAIN};
    localparam logic [2:0] RSV [3]  = '{3'h3, 3'h4, 3'h7};
    logic        clock, srst, sclk, cs_n, sdi, sdo_o, sdo_oe_n;
    logic [31:0] config_rd, setup_rd, reg_wdata, rd;
    logic [2:0]  reg_sel, conv_setup, setup_pointer_field;
    logic [2:0]  calibration_type_field;
    logic [1:0]  setup_index;
    logic        reg_wr, conv_start, repeat_conversion_flag;
    logic        cal_start, port_flag;
    logic [2:0]  ptr;
    int          bad_count = 0, n_tests = 0;
    int          n_wr = 0, n_conv = 0, n_cal = 0;

    acbd_decoder i_dut (.clock, .srst, .sclk, .cs_n, .sdi, .sdo_o,
        .sdo_oe_n, .config_rd, .setup_rd, .reg_sel, .setup_index,
        .reg_wr, .reg_wdata, .conv_start, .repeat_conversion_flag,
        .conv_setup, .cal_start, .setup_pointer_field,
        .calibration_type_field, .port_flag);
    acbd_host_model i_host (.sclk, .cs_n, .sdi, .sdo_o, .sdo_oe_n);

    // system clock, 8 ns
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // count one-cycle pulses where outputs are settled
    always @(negedge clock)
    begin
        if (reg_wr === 1'b1) n_wr++;
        if (conv_start === 1'b1) n_conv++;
        if (cal_start === 1'b1) n_cal++;
    end
    // one frame: command byte, optional 32-bit word
    task automatic op(input logic [7:0] c, input logic [31:0] wd,
                      input int n);
        i_host.sel(1'b1);
        i_host.shift({24'h0, c}, 8, rd);
        if (n != 0) i_host.shift(wd, 32, rd);
        i_host.sel(1'b0);
        repeat (10) @(negedge clock);
    endtask : op
    // the single exit of the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // hang guard
    initial
    begin
        #200000;
        bad_count++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        srst      = 1'b1;
        config_rd = 32'h0;
        setup_rd  = 32'h0;
        repeat (10) @(negedge clock);
        srst = 1'b0;
        repeat (2) @(negedge clock);
        // config write then conversion byte in the same frame
        i_host.sel(1'b1);
        i_host.shift(32'h03, 8, rd);
        i_host.shift(32'ha5c3_0f96, 32, rd);
        i_host.shift(32'h88, 8, rd);
        i_host.sel(1'b0);
        repeat (10) @(negedge clock);
        `CHECK(reg_sel, SEL_NONE)
        `CHECK(n_wr, 1)
        `CHECK(reg_wdata, 32'ha5c3_0f96)
        `CHECK(n_conv, 1)
        `CHECK({repeat_conversion_flag, conv_setup, port_flag}, 5'h03)
        // continuous conversion, then null byte
        op(8'hf8, 32'h0, 0);
        `CHECK({repeat_conversion_flag, conv_setup, port_flag}, 5'h1f)
        op(CMD_NULL, 32'h0, 0);
        `CHECK({repeat_conversion_flag, port_flag}, 2'b10)
        `CHECK(n_conv, 2)
        // config read
        config_rd = 32'h1234_5678;
        op(8'h0b, 32'h0, 1);
        `CHECK(rd, 32'h1234_5678)
        `CHECK(reg_sel, SEL_CONFIG)
        `CHECK({n_wr, sdo_oe_n}, {32'd1, 1'b1})
        // each setup register written, then read with bench-supplied contents
        for (int i = 0; i < 4; i++)
        begin
            setup_rd = 32'hc0de_0000 + i;
            op({2'b00, 2'(i), 4'h5}, 32'h5e70_0000 + i, 1);
            `CHECK(reg_wdata, 32'h5e70_0000 + i)
            `CHECK({reg_sel, setup_index}, {SEL_SETUP, 2'(i)})
            op({2'b00, 2'(i), 4'hd}, 32'h0, 1);
            `CHECK(rd, 32'hc0de_0000 + i)
        end
        `CHECK(n_wr, 5)
        // every calibration type, pointers from 000 to 111
        for (int i = 0; i < 4; i++)
        begin
            ptr = 3'(i * 7 / 3);
            op({2'b10, ptr, CALS[i]}, 32'h0, 0);
            `CHECK(n_cal, i + 1)
            `CHECK({setup_pointer_field, calibration_type_field}, {ptr, CALS[i]})
        end
        // reserved calibration codes change nothing
        for (int i = 0; i < 3; i++) op({5'h12, RSV[i]}, 32'h0, 0);
        `CHECK(n_cal, 4)
        `CHECK({setup_pointer_field, calibration_type_field}, 6'h3e)
        `CHECK(n_conv, 2)
        give_verdict();
    end
endmodule : acbd_decoder_bench
